// ---- hdl/kip_switch_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module kip_switch_unit #(
    parameter int AUTH_OFF_CYC = kip_pkg::KIP_AUTH_OFF_CYC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Front panel, enclosure and probe pins
    input wire kip_pkg::kip_pins_t i_pins,
    // Keyboard and mouse reports from the shared port
    input wire logic i_hid_valid,
    input wire kip_pkg::kip_hid_t i_hid,
    output logic o_hid_in_ready,
    // Reports towards the hosts
    output logic o_hid_valid,
    output kip_pkg::kip_word_t o_hid,
    input wire logic i_hid_ready,
    // Peripheral enumeration
    input wire logic [1:0] i_enum_valid,
    input wire logic [15:0] i_enum_class,
    output logic [1:0] o_query,
    output logic [1:0] o_periph_en,
    // Display and audio
    input wire logic i_aux_valid,
    input wire logic [1:0] i_aux_kind,
    input wire logic i_edid_xfer,
    output logic o_aux_pass,
    output logic o_aux_block,
    output logic o_edid_pass,
    output logic o_edid_direct,
    output logic [3:0] o_audio_route,
    output logic o_audio_rev_en,
    // Isolation gates
    output logic o_kbm_rev_en,
    output logic o_kbm_host_pwr_en,
    output logic [3:0] o_auth_route,
    output logic o_auth_pwr_en,
    // Housekeeping and indication
    output logic o_buf_purge,
    output logic o_cfg_erase,
    output logic o_tamper_nv_set,
    output logic o_fail_led,
    output logic o_normal,
    output logic [3:0] o_sel_led,
    output logic [3:0] o_auth_led
);
    import kip_pkg::*;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_sys_rst);

    kip_pins_t s1_r, s2_r, prev_r;
    kip_state_t state_r;
    logic [1:0] step_r;
    logic [KIP_TMR_W-1:0] tmr_r;
    logic [3:0] sel_r, auth_sel_r;
    logic [KIP_OFF_W-1:0] off_r;
    logic edid_used_r;
    logic [1:0] pend_r, wait_r;
    logic normal, tamper_ev, step_done, sel_chg, auth_chg;
    logic [3:0] sel_rise, auth_rise;
    logic hid_ok, buf_rdy, flush;

    // Pins pass two flops; the second is read, and a third flop holds its previous value for edge detection
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s1_r <= '0;
            s2_r <= '0;
            prev_r <= '0;
        end else begin
            s1_r <= i_pins;
            s2_r <= s1_r;
            prev_r <= s2_r;
        end
    end

    assign normal = (state_r == KIP_ST_RUN); // see R4
    assign tamper_ev = s2_r.tamper | ~s2_r.batt_ok | s2_r.tamper_nv;
    assign step_done = (tmr_r == KIP_TMR_W'(KIP_STEP_CYC - 1));
    assign sel_rise = s2_r.sel_btn & ~prev_r.sel_btn;
    assign auth_rise = s2_r.auth_btn & ~prev_r.auth_btn;
    assign sel_chg = normal && $onehot(sel_rise) && (sel_rise != sel_r);
    assign auth_chg = normal && $onehot(auth_rise)
        && (auth_rise != auth_sel_r);

    // Mode sequencer
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_r <= KIP_ST_INIT;
            step_r <= 2'h0;
            tmr_r <= '0;
        end else if (state_r != KIP_ST_INIT && tamper_ev) begin
            state_r <= KIP_ST_TAMP; // see R18
        end else begin
            case (state_r)
                KIP_ST_INIT: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (tmr_r == KIP_TMR_W'(KIP_SYNC_CYC - 1)) begin
                        state_r <= KIP_ST_TEST; // see R20
                        tmr_r <= '0;
                        step_r <= 2'h0;
                    end
                end
                KIP_ST_TEST: begin
                    tmr_r <= tmr_r + 8'h01;
                    if (!s2_r.tamper_fn_ok) begin
                        state_r <= KIP_ST_FAIL; // see R19
                    end else if (step_done) begin
                        tmr_r <= '0;
                        step_r <= step_r + 2'h1;
                        if (!s2_r.st_pass[step_r]) begin
                            state_r <= KIP_ST_FAIL; // see R19
                        end else if (step_r == 2'(KIP_NTEST - 1)) begin
                            state_r <= KIP_ST_RUN;
                        end
                    end
                end
                KIP_ST_RUN: begin
                    tmr_r <= '0;
                    step_r <= 2'h0;
                    if (!s2_r.tamper_fn_ok) begin
                        state_r <= KIP_ST_FAIL; // see R19
                    end else if (s2_r.rst_btn && !prev_r.rst_btn) begin
                        state_r <= KIP_ST_TEST; // see R20
                    end else if (s2_r.purge_btn && !prev_r.purge_btn) begin
                        state_r <= KIP_ST_CFG; // see R17
                    end
                end
                KIP_ST_CFG: state_r <= KIP_ST_INIT;
                KIP_ST_FAIL: state_r <= KIP_ST_FAIL;
                KIP_ST_TAMP: state_r <= KIP_ST_TAMP;
                default: state_r <= KIP_ST_TAMP;
            endcase
        end
    end

    a_tamper_lock: assert property ( // see R18
        state_r == KIP_ST_TAMP |=> state_r == KIP_ST_TAMP [*8])
        else $error("tamper state left");
    a_test_fail: assert property ( // see R19
        state_r == KIP_ST_TEST && step_done && s2_r.tamper_fn_ok
        && !s2_r.st_pass[step_r] && !tamper_ev
        |=> state_r == KIP_ST_FAIL)
        else $error("failed self-test not latched");
    c_reach_run: cover property (state_r == KIP_ST_RUN);
    c_tamper: cover property ($rose(state_r == KIP_ST_TAMP));

    // Host selections per group; purge restores the defaults
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            sel_r <= KIP_SEL_RST;
            auth_sel_r <= KIP_SEL_RST;
        end else begin
            if (state_r == KIP_ST_CFG) begin
                sel_r <= KIP_SEL_RST; // see R17
                auth_sel_r <= KIP_SEL_RST;
            end else begin
                if (sel_chg) begin
                    sel_r <= sel_rise;
                end
                if (auth_chg) begin
                    auth_sel_r <= auth_rise; // see R24
                end
            end
        end
    end

    // Authentication device is held unpowered after a host change
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            off_r <= '0;
        end else if (auth_chg) begin
            off_r <= KIP_OFF_W'(AUTH_OFF_CYC); // see R23
        end else if (off_r != '0) begin
            off_r <= off_r - 16'h0001;
        end
    end

    a_auth_pwr_off: assert property ( // see R23
        auth_chg |=> !o_auth_pwr_en [*8])
        else $error("auth device not power cycled");

    // Peripheral query and admission, one engine per console port
    genvar p;
    generate
        for (p = 0; p < KIP_NPORT; p++) begin : g_port
            localparam logic [7:0] CLS =
                (p == KIP_PORT_AUTH) ? KIP_CLS_AUTH : KIP_CLS_HID;
            always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    pend_r[p] <= 1'b1;
                    wait_r[p] <= 1'b0;
                    o_query[p] <= 1'b0;
                    o_periph_en[p] <= 1'b0;
                end else begin
                    o_query[p] <= 1'b0;
                    if (!s2_r.attach[p]) begin
                        o_periph_en[p] <= 1'b0;
                        wait_r[p] <= 1'b0;
                        pend_r[p] <= 1'b1;
                    end else if (pend_r[p] && state_r != KIP_ST_INIT) begin
                        o_query[p] <= 1'b1; // see R15
                        pend_r[p] <= 1'b0;
                        wait_r[p] <= 1'b1;
                    end else if (wait_r[p] && i_enum_valid[p]) begin
                        wait_r[p] <= 1'b0;
                        o_periph_en[p] <= // see R15
                            (i_enum_class[8*p +: 8] == CLS);
                    end
                end
            end
        end
    endgenerate

    a_reject_bad: assert property ( // see R15
        wait_r[KIP_PORT_KBM] && i_enum_valid[KIP_PORT_KBM]
        && s2_r.attach[KIP_PORT_KBM]
        && i_enum_class[7:0] != KIP_CLS_HID |=> !o_periph_en[KIP_PORT_KBM])
        else $error("unauthorised peripheral enabled");

    // Shared port carries keys and pointer reports alike; see R3
    assign hid_ok = i_hid_valid && normal && o_periph_en[KIP_PORT_KBM]
        && (i_hid.kind == KIP_KIND_KEY || i_hid.kind == KIP_KIND_PTR);
    // Held words are dropped on a switch and outside normal operation
    assign flush = sel_chg || !normal; // see R16

    // Word is taken when valid and ready; words that fail are dropped
    kip_buf2 u_buf (
        .i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst),
        .i_flush(flush),
        .i_valid(hid_ok), // see R1
        .i_data({sel_r, i_hid}), // see R5
        .o_ready(buf_rdy),
        .o_valid(o_hid_valid),
        .o_data(o_hid),
        .i_ready(i_hid_ready)
    );
    assign o_hid_in_ready = buf_rdy;

    a_hid_kind: assert property ( // see R1
        o_hid_valid |-> o_hid.hid.kind == KIP_KIND_KEY
        || o_hid.hid.kind == KIP_KIND_PTR)
        else $error("non-input data sent to host");
    a_hid_dest: assert property ( // see R5
        o_hid_valid |-> $onehot(o_hid.dest) && o_hid.dest == sel_r)
        else $error("report aimed at wrong host");
    c_hid_stall: cover property (o_hid_valid && !i_hid_ready ##1 !buf_rdy);

    // Routing gates, purge and erase strobes
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_kbm_rev_en <= 1'b0;
            o_kbm_host_pwr_en <= 1'b0;
            o_audio_rev_en <= 1'b0;
            o_edid_direct <= 1'b0;
            o_audio_route <= '0;
            o_auth_route <= '0;
            o_auth_pwr_en <= 1'b0;
            o_buf_purge <= 1'b1;
            o_cfg_erase <= 1'b0;
        end else begin
            o_kbm_rev_en <= 1'b0; // see R2
            o_kbm_host_pwr_en <= 1'b0; // see R6
            o_audio_rev_en <= 1'b0; // see R11
            o_edid_direct <= 1'b0; // see R14
            o_audio_route <= (normal && !s2_r.mic) ? sel_r : 4'h0; // see R10
            // Own selection, own gate: see R7, R8 and R9
            o_auth_route <= (normal && o_periph_en[KIP_PORT_AUTH]
                && off_r == '0 && !auth_chg) ? auth_sel_r : 4'h0;
            o_auth_pwr_en <= normal && off_r == '0 && !auth_chg; // see R23
            o_buf_purge <= sel_chg || state_r == KIP_ST_INIT; // see R16
            o_cfg_erase <= (state_r == KIP_ST_CFG); // see R17
        end
    end

    a_no_reverse: assert property ( // see R2
        !o_kbm_rev_en && !o_audio_rev_en)
        else $error("reverse path opened");
    a_no_host_pwr: assert property ( // see R6
        !o_kbm_host_pwr_en && !o_edid_direct)
        else $error("host power or EDID wire bridged");
    a_mic_cuts: assert property ( // see R10
        s2_r.mic |=> o_audio_route == 4'h0)
        else $error("audio open with microphone");
    a_auth_only_sel: assert property ( // see R7
        o_auth_route != 4'h0 |-> o_auth_route == auth_sel_r
        && $onehot(o_auth_route))
        else $error("auth data to unselected host");
    a_purge_switch: assert property ( // see R16
        sel_chg |=> o_buf_purge && !o_hid_valid)
        else $error("content kept across switch");
    c_sel_chg: cover property (sel_chg);

    // Display side filter
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_aux_pass <= 1'b0;
            o_aux_block <= 1'b0;
            o_edid_pass <= 1'b0;
            edid_used_r <= 1'b0;
        end else begin
            o_aux_pass <= i_aux_valid && normal && (i_aux_kind == KIP_AUX_NEG
                || i_aux_kind == KIP_AUX_TRAIN
                || i_aux_kind == KIP_AUX_EDID); // see R12
            o_aux_block <= i_aux_valid && !(normal
                && i_aux_kind != 2'h3); // see R12
            o_edid_pass <= i_edid_xfer && normal && !edid_used_r; // see R13
            if (state_r == KIP_ST_INIT) begin
                edid_used_r <= 1'b0;
            end else if (i_edid_xfer && normal) begin
                edid_used_r <= 1'b1; // see R13
            end
        end
    end

    a_aux_filter: assert property ( // see R12
        o_aux_pass |-> $past(i_aux_kind) != 2'h3)
        else $error("forbidden aux transaction passed");
    a_edid_once: assert property ( // see R13
        o_edid_pass |=> !o_edid_pass && edid_used_r)
        else $error("EDID passed twice");

    // Indicators and mode outputs
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_sel_led <= KIP_SEL_RST;
            o_auth_led <= KIP_SEL_RST;
            o_fail_led <= 1'b0;
            o_normal <= 1'b0;
            o_tamper_nv_set <= 1'b0;
        end else begin
            o_sel_led <= sel_r; // see R22
            o_auth_led <= auth_sel_r; // see R24
            o_fail_led <= state_r == KIP_ST_FAIL
                || state_r == KIP_ST_TAMP; // see R21
            o_normal <= normal; // see R4
            o_tamper_nv_set <= o_tamper_nv_set
                || state_r == KIP_ST_TAMP; // see R18
        end
    end

    a_led_follows: assert property ( // see R22
        ##1 o_sel_led == $past(sel_r) && o_auth_led == $past(auth_sel_r))
        else $error("selection indication stale");
    a_fail_lamp: assert property ( // see R21
        state_r == KIP_ST_FAIL |=> o_fail_led && !o_normal)
        else $error("fail lamp dark");
endmodule // kip_switch_unit
`default_nettype wire

// ---- hdl/kip_pkg.sv ----
// Functional notes
// R1: Only key codes and pointer reports reach host
// R2: Nothing flows from host to keyboard/mouse
// R3: Keyboard and mouse may share one port
// R4: Normal only when running, not testing/failed/tampered
// R5: No flow between any two hosts
// R6: No power path host to keyboard/mouse
// R7: Authentication data only to its selected host
// R8: Authentication routing kept apart from keyboard/mouse
// R9: No flow between different peripheral groups
// R10: Microphone present cuts the audio path
// R11: Audio flows host to speaker only
// R12: Aux channel passes negotiation, training, EDID only
// R13: Display EDID reaches host once per reset
// R14: No direct EDID wire host to display
// R15: Query peripherals, enable only authorised types
// R16: Purge held content on switch and start-up
// R17: User purge erases stored configuration
// R18: Tamper disables unit permanently, isolates all
// R19: Self-test or tamper-function failure disables unit
// R20: Self-test at start-up and reset button
// R21: Self-test failure lights front panel lamp
// R22: Selected host always shown, also in reset
// R23: Authentication device power-cycled on host change
// R24: Groups switch independently, each shown
package kip_pkg;
    localparam int KIP_NHOST = 4;
    localparam int KIP_NPORT = 2;
    localparam int KIP_PORT_KBM = 0;
    localparam int KIP_PORT_AUTH = 1;
    localparam int KIP_NTEST = 4;
    localparam int KIP_CLK_NS = 10;
    localparam int KIP_STEP_NS = 1000;
    localparam int KIP_STEP_CYC = (KIP_STEP_NS + KIP_CLK_NS - 1) / KIP_CLK_NS;
    localparam int KIP_AUTH_OFF_NS = 100000;
    localparam int KIP_AUTH_OFF_CYC =
        (KIP_AUTH_OFF_NS + KIP_CLK_NS - 1) / KIP_CLK_NS;
    localparam int KIP_SYNC_CYC = 3;
    localparam int KIP_TMR_W = 8;
    localparam int KIP_OFF_W = 16;
    localparam logic [1:0] KIP_KIND_KEY = 2'h1;
    localparam logic [1:0] KIP_KIND_PTR = 2'h2;
    localparam logic [1:0] KIP_AUX_NEG = 2'h0;
    localparam logic [1:0] KIP_AUX_TRAIN = 2'h1;
    localparam logic [1:0] KIP_AUX_EDID = 2'h2;
    localparam logic [7:0] KIP_CLS_HID = 8'h03;
    localparam logic [7:0] KIP_CLS_AUTH = 8'h0b;
    localparam logic [3:0] KIP_SEL_RST = 4'h1;

    typedef enum logic [2:0] {
        KIP_ST_INIT = 3'b000,
        KIP_ST_TEST = 3'b001,
        KIP_ST_CFG = 3'b010,
        KIP_ST_RUN = 3'b011,
        KIP_ST_FAIL = 3'b100,
        KIP_ST_TAMP = 3'b101
    } kip_state_t;

    typedef struct packed {
        logic [1:0] kind;
        logic [7:0] code;
    } kip_hid_t;

    typedef struct packed {
        logic [3:0] dest;
        kip_hid_t hid;
    } kip_word_t;

    typedef struct packed {
        logic [3:0] sel_btn;
        logic [3:0] auth_btn;
        logic rst_btn;
        logic purge_btn;
        logic tamper;
        logic batt_ok;
        logic tamper_nv;
        logic tamper_fn_ok;
        logic mic;
        logic [1:0] attach;
        logic [3:0] st_pass;
    } kip_pins_t;
endpackage

// ---- hdl/kip_buf2.sv ----
`timescale 1ns/1ps
`default_nettype none
module kip_buf2 (
    // Clock, reset and flush
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    input wire logic i_flush,
    // Fill side
    input wire logic i_valid,
    input wire kip_pkg::kip_word_t i_data,
    output logic o_ready,
    // Drain side
    output logic o_valid,
    output kip_pkg::kip_word_t o_data,
    input wire logic i_ready
);
    import kip_pkg::*;

    kip_word_t skid_r;
    logic skid_vld_r;

    // Ready is kept as a flop, always the inverse of the second entry
    // Second entry catches a word while the drain side stalls
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_valid <= 1'b0;
            o_data <= '0;
            skid_vld_r <= 1'b0;
            skid_r <= '0;
            o_ready <= 1'b1;
        end else if (i_flush) begin
            o_valid <= 1'b0;
            skid_vld_r <= 1'b0;
            o_ready <= 1'b1;
        end else if (!o_valid || i_ready) begin
            if (skid_vld_r) begin
                o_valid <= 1'b1;
                o_data <= skid_r;
                skid_vld_r <= 1'b0;
                o_ready <= 1'b1;
            end else begin
                o_valid <= i_valid;
                o_data <= i_data;
            end
        end else if (i_valid && !skid_vld_r) begin
            skid_r <= i_data;
            skid_vld_r <= 1'b1;
            o_ready <= 1'b0;
        end
    end
endmodule // kip_buf2
`default_nettype wire

// ---- verif/kip_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module kip_partner (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_sys_rst,
    // Controls from the bench
    input wire logic i_bad_class,
    input wire logic [1:0] i_stall,
    // Enumeration and host side
    input wire logic [1:0] i_query,
    output logic [1:0] o_enum_valid,
    output logic [15:0] o_enum_class,
    output logic o_hid_ready
);
    import kip_pkg::*;
    int dly [2];

    // Peripheral type answer, wrong only when the bench asks for it
    function automatic logic [7:0] cls(input int p);
        if (p == 0) begin
            return i_bad_class ? ~KIP_CLS_HID : KIP_CLS_HID;
        end
        return i_bad_class ? ~KIP_CLS_AUTH : KIP_CLS_AUTH;
    endfunction

    initial begin
        o_enum_valid = 2'h0;
        o_enum_class = 16'h0;
        o_hid_ready = 1'b1;
        dly[0] = 0;
        dly[1] = 0;
    end

    // Answers 1 to 5 cycles after a query; idle class lines toggle
    always @(negedge i_clk_sys) begin
        o_enum_valid <= 2'h0;
        o_enum_class <= ~o_enum_class;
        o_hid_ready <= (i_stall == 2'h0) ||
            (i_stall == 2'h1 && $urandom_range(0, 1) == 1);
        for (int p = 0; p < 2; p++) begin
            if (i_sys_rst) begin
                dly[p] = 0;
            end else if (i_query[p]) begin
                dly[p] = $urandom_range(1, 5);
            end else if (dly[p] > 0) begin
                dly[p]--;
                if (dly[p] == 0) begin
                    o_enum_valid[p] <= 1'b1;
                    o_enum_class[8*p +: 8] <= cls(p);
                end
            end
        end
    end
endmodule // kip_partner
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import kip_pkg::*;
    localparam int OFF = 20;
    logic i_clk_sys = 1'b0;
    logic i_sys_rst = 1'b1;
    kip_pins_t pins;
    kip_hid_t hid_in;
    kip_word_t out_w;
    kip_word_t q[$];
    logic hid_v, in_rdy, out_v, out_rdy, aux_v, edid_x, bad_class;
    logic [1:0] aux_k, stall, enum_v, query, pen;
    logic [15:0] enum_cls;
    logic aux_pass, aux_blk, edid_pass, edid_dir, aud_rev, kbm_rev;
    logic kbm_pwr, auth_pwr, purge, erase, nv_set, fail_led, normal;
    logic [3:0] aud_route, auth_route, sel_led, auth_led, exp_sel;
    logic purge_seen, erase_seen;
    int bad_count = 0;
    int checks_done = 0;
    int off_cnt = 0;

    always #5 i_clk_sys = ~i_clk_sys;

    kip_switch_unit #(.AUTH_OFF_CYC(OFF)) dut (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_pins(pins),
        .i_hid_valid(hid_v), .i_hid(hid_in), .o_hid_in_ready(in_rdy),
        .o_hid_valid(out_v), .o_hid(out_w), .i_hid_ready(out_rdy),
        .i_enum_valid(enum_v), .i_enum_class(enum_cls),
        .o_query(query), .o_periph_en(pen),
        .i_aux_valid(aux_v), .i_aux_kind(aux_k), .i_edid_xfer(edid_x),
        .o_aux_pass(aux_pass), .o_aux_block(aux_blk),
        .o_edid_pass(edid_pass), .o_edid_direct(edid_dir),
        .o_audio_route(aud_route), .o_audio_rev_en(aud_rev),
        .o_kbm_rev_en(kbm_rev), .o_kbm_host_pwr_en(kbm_pwr),
        .o_auth_route(auth_route), .o_auth_pwr_en(auth_pwr),
        .o_buf_purge(purge), .o_cfg_erase(erase),
        .o_tamper_nv_set(nv_set), .o_fail_led(fail_led),
        .o_normal(normal), .o_sel_led(sel_led), .o_auth_led(auth_led)
    );

    kip_partner peer (
        .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
        .i_bad_class(bad_class), .i_stall(stall), .i_query(query),
        .o_enum_valid(enum_v), .o_enum_class(enum_cls),
        .o_hid_ready(out_rdy)
    );

    task automatic chk(input string n, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk_sys);
    endtask

    task automatic wait_norm(input logic v);
        for (int i = 0; i < 1000 && normal !== v; i++) cyc(1);
        chk("normal wait", normal, v);
        if (normal !== v) report_and_stop;
    endtask

    task automatic press(input int h, input bit auth);
        if (auth) pins.auth_btn = 4'h1 << h;
        else pins.sel_btn = 4'h1 << h;
        cyc(2);
        pins.sel_btn = 4'h0;
        pins.auth_btn = 4'h0;
        cyc(6);
    endtask

    task automatic reboot(input logic up);
        i_sys_rst = 1'b1;
        cyc(3);
        i_sys_rst = 1'b0;
        if (up) wait_norm(1'b1);
        exp_sel = KIP_SEL_RST;
    endtask

    // Reference model of the report path and event watchers
    always @(posedge i_clk_sys) begin
        if (purge) purge_seen = 1'b1;
        if (erase) erase_seen = 1'b1;
        if (!auth_pwr && normal) off_cnt++;
        if (hid_v && in_rdy && normal && pen[0] &&
            (hid_in.kind == KIP_KIND_KEY || hid_in.kind == KIP_KIND_PTR))
            q.push_back('{dest: exp_sel, hid: hid_in});
        if (out_v && out_rdy) begin
            if (q.size() == 0) chk("hid extra", 1, 0);
            else chk("hid word", out_w, q.pop_front());
        end
    end

    initial begin
        int s;
        logic ok;
        s = $urandom(65578);
        pins = '0;
        pins.batt_ok = 1'b1;
        pins.tamper_fn_ok = 1'b1;
        pins.st_pass = 4'hf;
        {hid_v, aux_v, edid_x, bad_class} = 4'h0;
        hid_in = '0;
        aux_k = 2'h0;
        stall = 2'h0;
        exp_sel = KIP_SEL_RST;
        cyc(1);
        chk("sel led in reset", sel_led, KIP_SEL_RST);
        chk("auth led in reset", auth_led, KIP_SEL_RST);
        chk("purge in reset", purge, 1);
        cyc(2);
        i_sys_rst = 1'b0;
        wait_norm(1'b1);
        $display("test reset done");
        for (int i = 0; i < 3; i++) begin
            bad_class = (i == 1);
            pins.attach = 2'b00;
            cyc(6);
            pins.attach = 2'b11;
            cyc(14);
            chk("periph enable", pen, {~bad_class, ~bad_class});
        end
        $display("test enumeration done");
        for (int i = 0; i < 4; i++) begin
            aux_v = 1'b1;
            aux_k = i[1:0];
            cyc(1);
            chk("aux pass", aux_pass, i != 3);
            chk("aux block", aux_blk, i == 3);
        end
        aux_v = 1'b0;
        for (int i = 0; i < 2; i++) begin
            edid_x = 1'b1;
            cyc(1);
            edid_x = 1'b0;
            chk("edid pass", edid_pass, i == 0);
            cyc(1);
        end
        chk("reverse gates", {edid_dir, aud_rev, kbm_rev, kbm_pwr}, 0);
        $display("test display done");
        purge_seen = 1'b0;
        press(2, 1'b0);
        exp_sel = 4'h4;
        chk("sel led", sel_led, 4'h4);
        chk("purge on switch", purge_seen, 1);
        chk("audio route", aud_route, 4'h4);
        pins.mic = 1'b1;
        cyc(6);
        chk("audio cut by mic", aud_route, 0);
        pins.mic = 1'b0;
        off_cnt = 0;
        press(3, 1'b1);
        cyc(60);
        chk("auth power off", off_cnt, OFF + 1);
        chk("auth led", auth_led, 4'h8);
        chk("auth route", auth_route, 4'h8);
        chk("kbm sel kept", sel_led, 4'h4);
        $display("test selection done");
        stall = 2'h1;
        for (int n = 0; n < 40; n++) begin
            hid_v = 1'b1;
            hid_in.kind = 2'($urandom_range(0, 3));
            hid_in.code = 8'($urandom);
            ok = 1'b0;
            for (int i = 0; i < 50 && !ok; i++) begin
                ok = in_rdy;
                cyc(1);
            end
            chk("hid taken", ok, 1);
            if (!ok) report_and_stop;
        end
        hid_in.kind = KIP_KIND_KEY;
        stall = 2'h2;
        cyc(10);
        chk("buffer full", in_rdy, 0);
        hid_v = 1'b0;
        stall = 2'h0;
        for (int i = 0; i < 50 && q.size() != 0; i++) cyc(1);
        chk("hid drained", q.size(), 0);
        if (q.size() != 0) report_and_stop;
        $display("test report path done");
        erase_seen = 1'b0;
        pins.purge_btn = 1'b1;
        cyc(2);
        pins.purge_btn = 1'b0;
        wait_norm(1'b0);
        cyc(1);
        chk("config erase", erase_seen, 1);
        chk("sel after purge", sel_led, KIP_SEL_RST);
        wait_norm(1'b1);
        exp_sel = KIP_SEL_RST;
        $display("test purge done");
        pins.st_pass = 4'hd;
        pins.rst_btn = 1'b1;
        cyc(2);
        pins.rst_btn = 1'b0;
        cyc(500);
        chk("fail lamp", fail_led, 1);
        chk("fail disables", normal, 0);
        pins.st_pass = 4'hf;
        reboot(1'b1);
        pins.tamper_fn_ok = 1'b0;
        cyc(6);
        chk("tamper fn fail", normal, 0);
        pins.tamper_fn_ok = 1'b1;
        reboot(1'b1);
        $display("test failures done");
        pins.tamper = 1'b1;
        cyc(6);
        chk("tamper off", normal, 0);
        chk("tamper stored", nv_set, 1);
        chk("tamper isolation", {auth_route, aud_route}, 0);
        pins.tamper = 1'b0;
        pins.tamper_nv = nv_set;
        reboot(1'b0);
        cyc(500);
        chk("tamper permanent", normal, 0);
        $display("test tamper done");
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
